// ==== logic/reset_init_pkg.sv ====
// Package for the reset value initializer: register slots, byte-lane layout,
// initial value columns, bit masks and the bus and cause carriers.
// Assumes a 32-bit APB with a 12-bit byte address and one register per word.
package reset_init_pkg;

  localparam int NREG = 37;

  // Printed register offsets (register index; byte address is index times four)
  localparam logic [8:0] OFF_CAPTURE2_VALUE_HIGH      = 9'h01C;
  localparam logic [8:0] OFF_CAPTURE2_CONTROL         = 9'h01D;
  localparam logic [8:0] OFF_CONVERSION_RESULT_HIGH   = 9'h01E;
  localparam logic [8:0] OFF_CONVERTER_CONTROL0       = 9'h01F;
  localparam logic [8:0] OFF_CORE_OPTION_SETTINGS     = 9'h081;
  localparam logic [8:0] OFF_PORT_A_DIRECTION         = 9'h085;
  localparam logic [8:0] OFF_PORT_B_DIRECTION         = 9'h086;
  localparam logic [8:0] OFF_PORT_C_DIRECTION         = 9'h087;
  localparam logic [8:0] OFF_PORT_D_DIRECTION         = 9'h088;
  localparam logic [8:0] OFF_PORT_E_DIRECTION         = 9'h089;
  localparam logic [8:0] OFF_PERIPHERAL_IRQ_ENABLE1   = 9'h08C;
  localparam logic [8:0] OFF_PERIPHERAL_IRQ_ENABLE2   = 9'h08D;
  localparam logic [8:0] OFF_POWER_CONTROL_FLAGS      = 9'h08E;
  localparam logic [8:0] OFF_OSCILLATOR_CONTROL       = 9'h08F;
  localparam logic [8:0] OFF_OSCILLATOR_TUNING        = 9'h090;
  localparam logic [8:0] OFF_SERIAL_PORT_CONTROL2     = 9'h091;
  localparam logic [8:0] OFF_TIMER2_PERIOD            = 9'h092;
  localparam logic [8:0] OFF_SERIAL_SHARED            = 9'h093;
  localparam logic [8:0] OFF_SERIAL_PORT_STATE        = 9'h094;
  localparam logic [8:0] OFF_PORT_B_PULLUPS           = 9'h095;
  localparam logic [8:0] OFF_PORT_B_CHANGE_ENABLE     = 9'h096;
  localparam logic [8:0] OFF_VOLTAGE_REF_CONTROL      = 9'h097;
  localparam logic [8:0] OFF_UART_TX_CONTROL          = 9'h098;
  localparam logic [8:0] OFF_BAUD_DIVISOR_LOW         = 9'h099;
  localparam logic [8:0] OFF_BAUD_DIVISOR_HIGH        = 9'h09A;
  localparam logic [8:0] OFF_PWM_DEADBAND_CONTROL     = 9'h09B;
  localparam logic [8:0] OFF_PWM_AUTOSHUTDOWN_CONTROL = 9'h09C;
  localparam logic [8:0] OFF_PWM_STEERING_CONTROL     = 9'h09D;
  localparam logic [8:0] OFF_CONVERSION_RESULT_LOW    = 9'h09E;
  localparam logic [8:0] OFF_CONVERTER_CONTROL1       = 9'h09F;
  localparam logic [8:0] OFF_WATCHDOG_CONTROL         = 9'h105;
  localparam logic [8:0] OFF_COMPARATOR1_CONTROL      = 9'h107;
  localparam logic [8:0] OFF_COMPARATOR2_CONTROL      = 9'h108;
  localparam logic [8:0] OFF_INTERRUPT_CONTROL        = 9'h00B;
  localparam logic [8:0] OFF_PERIPHERAL_REQUEST       = 9'h00C;
  localparam logic [8:0] OFF_SERIAL_PORT_CONTROL      = 9'h014;

  // Storage slots that the logic treats specially
  localparam int SLOT_POWER       = 12;
  localparam int SLOT_OSC         = 13;
  localparam int SLOT_SLAVE       = 17;
  localparam int SLOT_MASK        = 18;
  localparam int SLOT_IRQ_CTRL    = 34;
  localparam int SLOT_IRQ_REQ     = 35;
  localparam int SLOT_SERIAL_CTRL = 36;

  // Offset of each slot; the slave address and the mask share one offset
  localparam logic [8:0] REG_OFFSET [NREG] = '{
    OFF_CAPTURE2_VALUE_HIGH, OFF_CAPTURE2_CONTROL, OFF_CONVERSION_RESULT_HIGH,
    OFF_CONVERTER_CONTROL0, OFF_CORE_OPTION_SETTINGS, OFF_PORT_A_DIRECTION,
    OFF_PORT_B_DIRECTION, OFF_PORT_C_DIRECTION, OFF_PORT_D_DIRECTION,
    OFF_PORT_E_DIRECTION, OFF_PERIPHERAL_IRQ_ENABLE1, OFF_PERIPHERAL_IRQ_ENABLE2,
    OFF_POWER_CONTROL_FLAGS, OFF_OSCILLATOR_CONTROL, OFF_OSCILLATOR_TUNING,
    OFF_SERIAL_PORT_CONTROL2, OFF_TIMER2_PERIOD, OFF_SERIAL_SHARED, OFF_SERIAL_SHARED,
    OFF_SERIAL_PORT_STATE, OFF_PORT_B_PULLUPS, OFF_PORT_B_CHANGE_ENABLE,
    OFF_VOLTAGE_REF_CONTROL, OFF_UART_TX_CONTROL, OFF_BAUD_DIVISOR_LOW,
    OFF_BAUD_DIVISOR_HIGH, OFF_PWM_DEADBAND_CONTROL, OFF_PWM_AUTOSHUTDOWN_CONTROL,
    OFF_PWM_STEERING_CONTROL, OFF_CONVERSION_RESULT_LOW, OFF_CONVERTER_CONTROL1,
    OFF_WATCHDOG_CONTROL, OFF_COMPARATOR1_CONTROL, OFF_COMPARATOR2_CONTROL,
    OFF_INTERRUPT_CONTROL, OFF_PERIPHERAL_REQUEST, OFF_SERIAL_PORT_CONTROL};

  // Implemented bits; all others read as zero
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'hFF, 8'h3F, 8'hFF, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
    8'hFF, 8'hFF, 8'h33, 8'h7F, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF,
    8'hB0, 8'h1F, 8'hFB, 8'hFB, 8'hFF, 8'hFF, 8'hFF};

  // Power-on column (unknown bits taken as zero)
  localparam logic [7:0] REG_POR [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
    8'h00, 8'h00, 8'h10, 8'h60, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00,
    8'hFF, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Bits kept on external and watchdog resets and, except power flag bit zero, on brown-out without supply_low
  localparam logic [7:0] REG_RST_KEEP [NREG] = '{
    8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h13, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

  // Power, oscillator and interrupt-control bits; serial mask mode; vector
  localparam int BIT_BROWNOUT    = 0;
  localparam int BIT_POWERON     = 1;
  localparam int BIT_SW_BROWNOUT = 4;
  localparam int BIT_ULP_WAKE    = 5;
  localparam int BIT_OSC_COND    = 3;
  localparam int BIT_IRQ_ENABLE  = 7;
  localparam logic [3:0]  SERIAL_MASK_MODE = 4'b1001;
  localparam logic [12:0] IRQ_VECTOR       = 13'h0004;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  // One-hot reset or wake cause from the reset logic
  typedef struct packed {
    logic power_on;
    logic external;
    logic watchdog;
    logic brownout;
    logic wake_irq;
    logic wake_wdt;
  } reset_cause_type;

  // Wake source flags to record on an interrupt wake-up
  typedef struct packed {
    logic [2:0] irq_ctrl_flags;
    logic [7:0] irq_req_flags;
  } wake_flags_type;

  typedef enum logic [2:0] {COL_NONE, COL_POR, COL_RESET, COL_WAKE} column_type;

endpackage

// ==== logic/reset_value_initializer.sv ====
// Register bank that loads its initial contents according to the reset or
// wake-up cause, reachable as an APB slave.
// Assumes cause, flag and condition inputs come from logic on pclk.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

// What this block does
// RQ1: Wake-up keeps all retaining bits unchanged
// RQ2: Unimplemented bits always read as zero
// RQ3: Condition bits load from live hardware condition
// RQ4: Interrupt wake sets wake source flag bits
// RQ5: Interrupt wake with enable loads vector
// RQ6: Brown-out without supply_low clears power flag bit zero; other resets keep it
// RQ7: Shared address reaches mask in mode 1001
// RQ8: Resets load ones and printed constants
// RQ9: Period and mask become ones always
// RQ10: Brown-out at low supply uses power-on
// RQ11: Every reset clears global interrupt enable
// RQ12: One-hot cause applied within one cycle
module reset_value_initializer (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire reset_init_pkg::apb_req_type     apb_req,
  output      reset_init_pkg::apb_rsp_type     apb_rsp,
  input  wire reset_init_pkg::reset_cause_type reset_cause,
  input  wire logic                            supply_low,
  input  wire logic                            osc_condition,
  input  wire reset_init_pkg::wake_flags_type  wake_flags,
  output      logic [reset_init_pkg::NREG-1:0][7:0] reg_image,
  output      logic                            global_interrupt_enable,
  output      logic                            vector_load,
  output      logic [12:0]                     vector_addr
);

  localparam int NREG = reset_init_pkg::NREG;

  logic [NREG-1:0][7:0]            regs_q;
  reset_init_pkg::reset_cause_type cause_prev_q;
  reset_init_pkg::reset_cause_type cause_rise;
  reset_init_pkg::column_type      column;
  logic                            is_brownout;
  logic                            mask_mode;
  logic                            access;
  logic                            wr_fire;
  logic                            hit;
  logic [5:0]                      hit_slot;
  logic [31:0]                     rd_word;
  logic                            pready_q;
  logic                            pslverr_q;
  logic [31:0]                     prdata_q;
  logic                            vector_load_q;
  logic [12:0]                     vector_addr_q;

  // Edge of each cause so a held cause is applied once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_prev_q <= '0;
    else
      cause_prev_q <= reset_cause;
  end

  assign cause_rise = reset_cause & ~cause_prev_q;

  // Pick the column of initial values; power-on outranks the rest
  always_comb
  begin
    column      = reset_init_pkg::COL_NONE;
    is_brownout = 1'b0;
    if (cause_rise.power_on)
      column = reset_init_pkg::COL_POR;
    else if (cause_rise.brownout && supply_low)
      column = reset_init_pkg::COL_POR; // [RQ10]
    else if (cause_rise.external || cause_rise.watchdog || cause_rise.brownout)
    begin
      column      = reset_init_pkg::COL_RESET; // [RQ12]
      is_brownout = cause_rise.brownout;
    end
    else if (cause_rise.wake_irq || cause_rise.wake_wdt)
      column = reset_init_pkg::COL_WAKE;
  end

  // Shared offset steers to the mask only in the address-mask mode
  assign mask_mode = regs_q[reset_init_pkg::SLOT_SERIAL_CTRL][3:0]
                     == reset_init_pkg::SERIAL_MASK_MODE; // [RQ7]

  // Address decode: aligned word whose index matches a slot
  always_comb
  begin
    hit      = 1'b0;
    hit_slot = '0;
    for (int i = 0; i < NREG; i++)
    begin
      if (apb_req.paddr[1:0] == 2'b00 &&
          apb_req.paddr[11:2] == {1'b0, reset_init_pkg::REG_OFFSET[i]})
      begin
        if (i == reset_init_pkg::SLOT_SLAVE && mask_mode)
          hit = hit;
        else if (i == reset_init_pkg::SLOT_MASK && !mask_mode)
          hit = hit; // [RQ7]
        else
        begin
          hit      = 1'b1;
          hit_slot = 6'(i);
        end
      end
    end
  end

  // Read data, masked to implemented bits
  always_comb
  begin
    rd_word = '0;
    if (hit)
      rd_word[7:0] = regs_q[hit_slot] & reset_init_pkg::REG_MASK[hit_slot]; // [RQ2]
  end

  // APB handshake: one wait state, answer in the second access cycle
  assign access  = apb_req.psel && apb_req.penable;
  assign wr_fire = access && pready_q && apb_req.pwrite && hit && apb_req.pstrb[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else if (access && !pready_q)
    begin
      pready_q  <= 1'b1;
      pslverr_q <= !hit;
      prdata_q  <= apb_req.pwrite ? 32'h0000_0000 : rd_word;
    end
    else
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
  end

  // Register storage: cause loading outranks a bus write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= reset_init_pkg::REG_POR[i];
    end
    else
    begin
      case (column)
        reset_init_pkg::COL_POR:
        begin
          for (int i = 0; i < NREG; i++)
            regs_q[i] <= reset_init_pkg::REG_POR[i]; // [RQ8]
          // Brown-out flag is unknown at power-on, so it is left alone
          regs_q[reset_init_pkg::SLOT_POWER][reset_init_pkg::BIT_BROWNOUT] <=
            regs_q[reset_init_pkg::SLOT_POWER][reset_init_pkg::BIT_BROWNOUT];
          regs_q[reset_init_pkg::SLOT_OSC][reset_init_pkg::BIT_OSC_COND] <=
            osc_condition; // [RQ3]
        end
        reset_init_pkg::COL_RESET:
        begin
          for (int i = 0; i < NREG; i++)
            regs_q[i] <= ((regs_q[i] & reset_init_pkg::REG_RST_KEEP[i]) |
                          (reset_init_pkg::REG_POR[i] & ~reset_init_pkg::REG_RST_KEEP[i]))
                         & reset_init_pkg::REG_MASK[i]; // [RQ8] [RQ11]
          regs_q[reset_init_pkg::SLOT_OSC][reset_init_pkg::BIT_OSC_COND] <=
            osc_condition; // [RQ3]
          // Brown-out clears its flag; other resets keep it
          if (is_brownout)
            regs_q[reset_init_pkg::SLOT_POWER][reset_init_pkg::BIT_BROWNOUT] <= 1'b0; // [RQ6]
        end
        reset_init_pkg::COL_WAKE:
        begin
          // Everything retained except period and mask; an interrupt wake also sets wake flags
          regs_q[reset_init_pkg::SLOT_MASK] <= 8'hFF; // [RQ9] [RQ1]
          regs_q[16] <= reset_init_pkg::REG_POR[16]; // [RQ9]
          if (cause_rise.wake_irq)
          begin
            regs_q[reset_init_pkg::SLOT_IRQ_CTRL][2:0] <=
              regs_q[reset_init_pkg::SLOT_IRQ_CTRL][2:0] | wake_flags.irq_ctrl_flags; // [RQ4]
            regs_q[reset_init_pkg::SLOT_IRQ_REQ] <=
              regs_q[reset_init_pkg::SLOT_IRQ_REQ] | wake_flags.irq_req_flags; // [RQ4]
          end
        end
        default:
        begin
          if (wr_fire)
            regs_q[hit_slot] <= apb_req.pwdata[7:0] & reset_init_pkg::REG_MASK[hit_slot];
        end
      endcase
    end
  end

  // Vector load pulse on an interrupt wake while the global enable is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vector_load_q <= 1'b0;
      vector_addr_q <= '0;
    end
    else
    begin
      vector_load_q <= column == reset_init_pkg::COL_WAKE && cause_rise.wake_irq &&
                       global_interrupt_enable; // [RQ5]
      vector_addr_q <= reset_init_pkg::IRQ_VECTOR;
    end
  end

  // Outputs straight from flip-flops
  assign apb_rsp.pready           = pready_q;
  assign apb_rsp.pslverr          = pslverr_q;
  assign apb_rsp.prdata           = prdata_q;
  assign reg_image                = regs_q;
  assign global_interrupt_enable  =
    regs_q[reset_init_pkg::SLOT_IRQ_CTRL][reset_init_pkg::BIT_IRQ_ENABLE]; // [RQ11]
  assign vector_load              = vector_load_q;
  assign vector_addr              = vector_addr_q;

endmodule

// ==== verification/reset_value_initializer_assertions.sv ====
// Checker for the reset value initializer: cause handling and bank contents.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module reset_value_initializer_assertions (
  input wire logic                                 pclk,
  input wire logic                                 presetn,
  input wire reset_init_pkg::apb_req_type          apb_req,
  input wire reset_init_pkg::apb_rsp_type          apb_rsp,
  input wire reset_init_pkg::reset_cause_type      reset_cause,
  input wire logic                                 supply_low,
  input wire logic                                 osc_condition,
  input wire reset_init_pkg::wake_flags_type       wake_flags,
  input wire logic [reset_init_pkg::NREG-1:0][7:0] reg_image,
  input wire logic                                 global_interrupt_enable,
  input wire logic                                 vector_load,
  input wire logic [12:0]                          vector_addr
);
  reset_init_pkg::reset_cause_type prev_q;
  reset_init_pkg::reset_cause_type rise;
  logic                            any_reset;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Previous cause level, for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_q <= '0;
    else
      prev_q <= reset_cause;
  end
  // Rising cause bits and the reset kinds among them
  assign rise = reset_init_pkg::reset_cause_type'(reset_cause & ~prev_q);
  assign any_reset = rise.power_on | rise.external | rise.watchdog | rise.brownout;
  chk_period_ones: assert property (rise != '0
    |=> reg_image[16] == 8'hFF && reg_image[18] == 8'hFF)
    else $error("period or mask not all ones after a cause");
  chk_wake_keeps: assert property ((rise.wake_irq | rise.wake_wdt)
    |=> $stable(reg_image[15:0]))
    else $error("wake changed a retained register");
  chk_enable_cleared: assert property (any_reset |=> !global_interrupt_enable)
    else $error("interrupt enable survived a reset");
  chk_osc_loaded: assert property (any_reset |=> reg_image[13][3] == $past(osc_condition))
    else $error("oscillator condition bit not loaded");
  chk_flag_cleared: assert property (rise.brownout && !supply_low |=> !reg_image[12][0])
    else $error("brown-out flag not cleared");
  chk_flag_kept: assert property ((rise.external | rise.watchdog)
    |=> $stable(reg_image[12][0]))
    else $error("brown-out flag changed by another reset");
  chk_low_supply_por: assert property ((rise.power_on | rise.brownout & supply_low)
    |=> reg_image[12][5:1] == 5'b01000)
    else $error("power-on column not applied");
  chk_vector_load: assert property (rise.wake_irq && global_interrupt_enable
    |=> vector_load && vector_addr == 13'h0004)
    else $error("vector not loaded on interrupt wake");
  chk_no_vector: assert property (rise.wake_irq && !global_interrupt_enable
    |=> !vector_load)
    else $error("vector loaded with interrupts disabled");
  chk_wake_flags: assert property (rise.wake_irq |=>
    (reg_image[35] & $past(wake_flags.irq_req_flags)) == $past(wake_flags.irq_req_flags))
    else $error("wake source flag not recorded");
  chk_unimpl_zero: assert property (reg_image[9][7:4] == 4'h0
    && reg_image[12][7:6] == 2'h0)
    else $error("unimplemented bit set");
endmodule
bind reset_value_initializer reset_value_initializer_assertions u_chk (.pclk, .presetn, .apb_req,
  .apb_rsp, .reset_cause, .supply_low, .osc_condition, .wake_flags, .reg_image,
  .global_interrupt_enable, .vector_load, .vector_addr);

// ==== verification/testbench.sv ====
// Testbench for the reset value initializer: APB accesses and cause pulses.
// Assumes the package is compiled first and the checker is bound to the design.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic                                 pclk;
  logic                                 presetn;
  reset_init_pkg::apb_req_type          apb_req;
  reset_init_pkg::apb_rsp_type          apb_rsp;
  reset_init_pkg::reset_cause_type      reset_cause;
  logic                                 supply_low;
  logic                                 osc_condition;
  reset_init_pkg::wake_flags_type       wake_flags;
  logic [reset_init_pkg::NREG-1:0][7:0] reg_image;
  logic                                 irq_enable;
  logic                                 vector_load;
  logic [12:0]                          vector_addr;
  int                                   num_errors;
  int                                   tests_run;
  logic [7:0]                           rd;
  logic                                 er;
  logic                                 vl;
  localparam logic [8:0] tbl_idx [15] = '{9'h081, 9'h085, 9'h086, 9'h087, 9'h088, 9'h089,
    9'h08E, 9'h08F, 9'h092, 9'h093, 9'h095, 9'h098, 9'h09D, 9'h105, 9'h01D};
  localparam logic [7:0] tbl_val [15] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
    8'h10, 8'h60, 8'hFF, 8'h00, 8'hFF, 8'h02, 8'h01, 8'h08, 8'h00};
  localparam logic [8:0] msk_idx [4] = '{9'h089, 9'h08E, 9'h08F, 9'h01F};
  localparam logic [7:0] msk_val [4] = '{8'h0F, 8'h33, 8'h7F, 8'hDF};
  localparam logic [5:0] rst_kind [4] = '{6'h20, 6'h10, 6'h08, 6'h04};
  reset_value_initializer u_reset_value_initializer (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .reset_cause(reset_cause), .supply_low(supply_low),
    .osc_condition(osc_condition), .wake_flags(wake_flags), .reg_image(reg_image),
    .global_interrupt_enable(irq_enable), .vector_load(vector_load), .vector_addr(vector_addr));
  // Clock at 25 MHz
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer, waiting a bounded time for pready
  task automatic xfer(input logic wr, input logic [8:0] idx, input logic [7:0] wd);
    int n;
    apb_req <= '{1'b1, 1'b0, wr, {1'b0, idx, 2'b00}, {24'h0, wd}, 4'hF};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1)
    begin
      num_errors++;
      stop_test();
    end
    else
    begin
      rd = apb_rsp.prdata[7:0];
      er = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge pclk);
    end
  endtask
  // Read one register and compare its byte
  task automatic rchk(input logic [8:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    `CHECK($sformatf("reg %h", idx), exp, rd)
  endtask
  // One-cycle cause pulse; vector_load is sampled once it has settled
  task automatic pulse(input logic [5:0] c);
    reset_cause <= c;
    @(posedge pclk);
    reset_cause <= '0;
    @(negedge pclk);
    vl = vector_load;
    @(posedge pclk);
  endtask
  // Main sequence
  initial
  begin
    num_errors = 0;
    tests_run = 0;
    apb_req = '0;
    reset_cause = '0;
    supply_low = 1'b0;
    osc_condition = 1'b0;
    wake_flags = '0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 15; i++)
      rchk(tbl_idx[i], tbl_val[i]);
    `CHECK("mask", 8'hFF, reg_image[reset_init_pkg::SLOT_MASK])
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, msk_idx[i], 8'hFF);
      rchk(msk_idx[i], msk_val[i]);
    end
    xfer(1'b1, 9'h000, 8'h55);
    xfer(1'b0, 9'h000, 8'h00);
    `CHECK("unmapped", 9'h100, {er, rd})
    xfer(1'b1, 9'h014, 8'h09);
    xfer(1'b1, 9'h093, 8'h5A);
    rchk(9'h093, 8'h5A);
    `CHECK("slave", 8'h00, reg_image[reset_init_pkg::SLOT_SLAVE])
    xfer(1'b1, 9'h014, 8'h00);
    xfer(1'b1, 9'h093, 8'h77);
    `CHECK("mask", 8'h5A, reg_image[reset_init_pkg::SLOT_MASK])
    xfer(1'b1, 9'h081, 8'h12);
    xfer(1'b1, 9'h092, 8'h34);
    pulse(6'h01);
    rchk(9'h081, 8'h12);
    rchk(9'h093, 8'h77);
    rchk(9'h092, 8'hFF);
    `CHECK("mask", 8'hFF, reg_image[reset_init_pkg::SLOT_MASK])
    xfer(1'b1, 9'h00B, 8'h80);
    wake_flags <= '{3'b001, 8'h02};
    pulse(6'h02);
    `CHECK("vector", 14'h2004, {vl, vector_addr})
    rchk(9'h00B, 8'h81);
    rchk(9'h00C, 8'h02);
    xfer(1'b1, 9'h00B, 8'h00);
    pulse(6'h02);
    `CHECK("no vector", 1'b0, vl)
    osc_condition <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, 9'h00B, 8'h81);
      xfer(1'b1, 9'h081, 8'h00);
      pulse(rst_kind[i]);
      `CHECK("enable", 1'b0, irq_enable)
      rchk(9'h081, 8'hFF);
      rchk(9'h08F, 8'h68);
    end
    xfer(1'b1, 9'h08E, 8'h13);
    xfer(1'b1, 9'h01C, 8'hAB);
    pulse(6'h08);
    rchk(9'h08E, 8'h13);
    pulse(6'h04);
    rchk(9'h08E, 8'h12);
    rchk(9'h01C, 8'hAB);
    xfer(1'b1, 9'h08E, 8'h13);
    pulse(6'h10);
    rchk(9'h08E, 8'h13);
    supply_low <= 1'b1;
    pulse(6'h04);
    xfer(1'b0, 9'h08E, 8'h00);
    `CHECK("power flags", 8'h10, rd & 8'h32)
    rchk(9'h01C, 8'h00);
    stop_test();
  end
endmodule
